/* File: include/usc_cfg.svh */
`ifndef USC_CFG_SVH
`define USC_CFG_SVH

// Register byte offsets
`define USC_OFF_ERR_EN    8'h00
`define USC_OFF_REPORT    8'h04
`define USC_OFF_CTRL      8'h08
`define USC_OFF_ERR_FLAG  8'h0C
`define USC_OFF_IRQ_FLAG  8'h10

// Error enable / error flag bit positions
`define USC_ERR_BITSTUFF  7
`define USC_ERR_BUFFER    5
`define USC_ERR_TURNAR    4
`define USC_ERR_BYTEALN   3
`define USC_ERR_CRC16     2
`define USC_ERR_CRC5      1
`define USC_ERR_PID       0
`define USC_ERR_USED      8'hBF

// Control bit positions
`define USC_CTL_HOLD      5
`define USC_CTL_RESUME    2
`define USC_CTL_PPCLR     1
`define USC_CTL_ENABLE    0

// Interrupt flag bit positions
`define USC_IRQ_TOKDONE   0
`define USC_IRQ_ERROR     1

// Reset values
`define USC_RST_BYTE      8'h00
`define USC_RST_WORD      32'h0000_0000

// Report queue and endpoint masks
`define USC_Q_DEPTH       3'h4
`define USC_EP_ALL        7'h7F
`define USC_EP_PINGPONG   7'h60

`endif

/* File: include/usc_pkg.sv */
package usc_pkg;

	// One finished transaction as seen by software
	typedef struct packed
	{
		logic [3:0] ep;
		logic       in_dir;
		logic       odd;
	} usc_txn_t;

	typedef struct packed
	{
		logic [7:0]          err_en;
		logic [7:0]          err_flag;
		logic [7:0]          report;
		logic                tok_flag;
		usc_txn_t [3:0]      q;
		logic [1:0]          rd;
		logic [1:0]          wr;
		logic [2:0]          cnt;
		logic                hold;
		logic                resume;
		logic                enable;
		logic [6:0]          odd_clr;
		logic                ack;
		logic [31:0]         dat;
	} usc_state_t;

endpackage

/* File: rtl/usc_regs.sv */
`timescale 1ns/1ps
`include "usc_cfg.svh"

// Summary of operation
// R1: Error enable bits 7,5,4 gate bit stuff, buffer, turnaround errors.
// R2: Error enable bits 3,2 gate byte alignment and CRC16 errors.
// R3: Error enable bits 1,0 gate CRC5 and packet id errors.
// R4: Transaction report is meaningful only while token complete flag is set.
// R5: Each finished descriptor use produces one status entry.
// R6: Status entries queue in a four-entry FIFO, not lost; code drops an entry that finishes while all four are full.
// R7: Clearing token complete loads next entry and re-raises flag at once; code re-raises it one cycle after the clear.
// R8: Report bits 7..4 hold endpoint number 0 to 6.
// R9: Report bit 3 is 1 for IN, 0 for OUT.
// R10: Report bit 2 is 1 for odd bank, 0 for even.
// R11: Setup token sets control bit 5 and halts packet traffic.
// R12: Clearing the hold flag resumes tokens; set keeps transfers off.
// R13: Control bit 2 drives resume signaling while 1.
// R14: Software holds the resume bit for the bus-mandated resume time.
// R15: Writing 1 to control bit 1 clears odd bank bits; 0 does nothing.
// R16: Ping-pong clear touches only endpoints 5 and 6.
// R17: Control bit 0 enables module; setting it resets odd bits and engine.
// R18: Enabling leaves transceiver and regulator untouched.
// R19: Enabled error flags are ORed into the error interrupt bit.
// R20: Error flags set on detection, clear only by writing 1.
// R21: Unused enable and control bits read 0, writes ignored.
module usc_regs
(
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        NRST,
	// Wishbone slave
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	input  wire logic        WB_WE_I,
	input  wire logic [7:0]  WB_ADR_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic [31:0] WB_DAT_I,
	output logic             WB_ACK_O,
	output logic      [31:0] WB_DAT_O,
	// Serial engine events
	input  wire logic [7:0]  ERR_EVT,
	input  wire logic        TXN_DONE,
	input  wire logic [3:0]  TXN_EP,
	input  wire logic        TXN_IN,
	input  wire logic        TXN_ODD,
	input  wire logic        SETUP_RX,
	// Serial engine control
	output logic             MOD_EN,
	output logic             ENGINE_RST,
	output logic      [6:0]  ODD_CLR,
	output logic             XFER_HOLD,
	output logic             RESUME_DRIVE,
	// Status levels
	output logic             TOK_DONE,
	output logic             ERR_IRQ
);

	function automatic logic hit(input logic [7:0] adr,
		input logic [7:0] off);
		hit = (adr == off);
	endfunction

	function automatic logic [7:0] pack_report(
		input usc_pkg::usc_txn_t t);
		pack_report = {t.ep, t.in_dir, t.odd, 2'h0};
	endfunction

	logic                rst_s1_r;
	logic                rst_n_r;
	usc_pkg::usc_state_t st_r;
	usc_pkg::usc_state_t st_nxt;
	logic                req;
	logic                wr_en;
	logic                rd_en;
	logic [7:0]          wbyte;
	logic                err_any;
	logic                push;
	logic                pop;
	logic [7:0]          ctl_view;
	logic [7:0]          irq_view;

	// Reset release through two flops
	always_ff @(posedge CLK or negedge NRST)
	begin
		if (!NRST)
		begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	assign req     = WB_CYC_I & WB_STB_I & ~st_r.ack;
	assign wr_en   = req & WB_WE_I & WB_SEL_I[0];
	assign rd_en   = req & ~WB_WE_I;
	assign wbyte   = WB_DAT_I[7:0];
	assign err_any = |(st_r.err_flag & st_r.err_en); // R19
	assign push    = TXN_DONE & (st_r.cnt != `USC_Q_DEPTH); // R5 R6
	assign ctl_view = {2'h0, st_r.hold, 2'h0, st_r.resume, 1'b0,
		st_r.enable}; // R21
	assign irq_view = {6'h00, err_any, st_r.tok_flag};

	always_comb
	begin
		st_nxt         = st_r;
		st_nxt.ack     = req;
		st_nxt.odd_clr = 7'h00;
		pop            = 1'b0;

		// Error flags: event wins over write-one-to-clear
		if (wr_en && hit(WB_ADR_I, `USC_OFF_ERR_FLAG))
			st_nxt.err_flag = st_r.err_flag & ~wbyte; // R20
		st_nxt.err_flag = (st_nxt.err_flag | ERR_EVT)
			& `USC_ERR_USED; // R20

		if (wr_en && hit(WB_ADR_I, `USC_OFF_ERR_EN))
			st_nxt.err_en = wbyte & `USC_ERR_USED; // R1 R2 R3 R21

		// Control register
		if (wr_en && hit(WB_ADR_I, `USC_OFF_CTRL))
		begin
			st_nxt.resume = wbyte[`USC_CTL_RESUME]; // R13
			st_nxt.enable = wbyte[`USC_CTL_ENABLE]; // R17
			if (!wbyte[`USC_CTL_HOLD])
				st_nxt.hold = 1'b0; // R12
			if (wbyte[`USC_CTL_PPCLR])
				st_nxt.odd_clr = `USC_EP_PINGPONG; // R15 R16
			if (wbyte[`USC_CTL_ENABLE] && !st_r.enable)
				st_nxt.odd_clr = `USC_EP_ALL; // R17 R18
		end
		if (SETUP_RX)
			st_nxt.hold = 1'b1; // R11

		// Token complete: clear, then reload from queue
		if (wr_en && hit(WB_ADR_I, `USC_OFF_IRQ_FLAG)
			&& wbyte[`USC_IRQ_TOKDONE])
			st_nxt.tok_flag = 1'b0; // R7
		if (!st_r.tok_flag && st_r.cnt != 3'h0)
		begin
			pop             = 1'b1;
			st_nxt.report   = pack_report(st_r.q[st_r.rd]); // R8 R9 R10
			st_nxt.tok_flag = 1'b1; // R7
			st_nxt.rd       = st_r.rd + 2'h1;
		end
		if (push)
		begin
			st_nxt.q[st_r.wr] = '{ep: TXN_EP, in_dir: TXN_IN,
				odd: TXN_ODD}; // R5
			st_nxt.wr = st_r.wr + 2'h1;
		end
		st_nxt.cnt = st_r.cnt + {2'h0, push} - {2'h0, pop}; // R6

		// Read data
		st_nxt.dat = `USC_RST_WORD;
		if (rd_en)
		begin
			unique case (1'b1)
				hit(WB_ADR_I, `USC_OFF_ERR_EN):
					st_nxt.dat[7:0] = st_r.err_en;
				hit(WB_ADR_I, `USC_OFF_REPORT):
					st_nxt.dat[7:0] = st_r.report; // R4
				hit(WB_ADR_I, `USC_OFF_CTRL):
					st_nxt.dat[7:0] = ctl_view;
				hit(WB_ADR_I, `USC_OFF_ERR_FLAG):
					st_nxt.dat[7:0] = st_r.err_flag;
				hit(WB_ADR_I, `USC_OFF_IRQ_FLAG):
					st_nxt.dat[7:0] = irq_view;
				default:
					st_nxt.dat = `USC_RST_WORD;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign WB_ACK_O     = st_r.ack;
	assign WB_DAT_O     = st_r.dat;
	assign MOD_EN       = st_r.enable;
	assign ENGINE_RST   = &st_r.odd_clr;
	assign ODD_CLR      = st_r.odd_clr;
	assign XFER_HOLD    = st_r.hold; // R12
	assign RESUME_DRIVE = st_r.resume; // R13
	assign TOK_DONE     = st_r.tok_flag;
	assign ERR_IRQ      = err_any; // R19

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!rst_n_r);

	a_err_irq_mask: assert property ( // R1
		ERR_IRQ == |(st_r.err_flag & st_r.err_en & `USC_ERR_USED))
		else $error("error irq does not match enabled flags");

	a_err_en_crc: assert property ( // R2
		(wr_en && hit(WB_ADR_I, `USC_OFF_ERR_EN)) |=>
		st_r.err_en[`USC_ERR_CRC16] == $past(wbyte[`USC_ERR_CRC16]))
		else $error("crc16 enable not written");

	a_err_en_pid: assert property ( // R3
		(st_r.err_flag[`USC_ERR_PID] && st_r.err_en[`USC_ERR_PID])
		|-> ERR_IRQ)
		else $error("pid error not raising irq");

	a_err_flag_set: assert property ( // R20
		ERR_EVT[`USC_ERR_CRC5] |=> st_r.err_flag[`USC_ERR_CRC5])
		else $error("error flag not set by event");

	a_err_flag_keep: assert property ( // R20
		(st_r.err_flag[`USC_ERR_BUFFER]
		&& !(wr_en && hit(WB_ADR_I, `USC_OFF_ERR_FLAG)))
		|=> st_r.err_flag[`USC_ERR_BUFFER])
		else $error("error flag lost without clear");

	a_queue_push: assert property ( // R5
		(TXN_DONE && st_r.cnt < `USC_Q_DEPTH && !pop)
		|=> st_r.cnt == $past(st_r.cnt) + 3'h1)
		else $error("finished transaction not queued");

	a_queue_bound: assert property ( // R6
		st_r.cnt <= `USC_Q_DEPTH)
		else $error("status queue overfilled");

	a_tok_reload: assert property ( // R7
		(!st_r.tok_flag && st_r.cnt != 3'h0) |=> st_r.tok_flag
		##0 st_r.report == pack_report($past(st_r.q[st_r.rd])))
		else $error("next status not loaded");

	a_report_fields: assert property ( // R8
		$rose(st_r.tok_flag) |-> st_r.report[1:0] == 2'h0
		&& st_r.report[7:4] == $past(st_r.q[st_r.rd].ep))
		else $error("report fields wrong");

	a_setup_hold: assert property ( // R11
		SETUP_RX |=> XFER_HOLD [*1] ##0 st_r.hold)
		else $error("setup did not set hold");

	a_hold_stays: assert property ( // R12
		(XFER_HOLD && !(wr_en && hit(WB_ADR_I, `USC_OFF_CTRL)))
		|=> XFER_HOLD)
		else $error("hold dropped without clear");

	a_resume_pin: assert property ( // R13
		(wr_en && hit(WB_ADR_I, `USC_OFF_CTRL)) |=>
		RESUME_DRIVE == $past(wbyte[`USC_CTL_RESUME]))
		else $error("resume drive not following control");

	a_pp_only56: assert property ( // R16
		(ODD_CLR != 7'h00) |-> (ODD_CLR == `USC_EP_PINGPONG
		|| ODD_CLR == `USC_EP_ALL))
		else $error("ping-pong clear hit wrong endpoints");

	a_enable_reset: assert property ( // R17
		$rose(MOD_EN) |-> ENGINE_RST ##1 !ENGINE_RST)
		else $error("enable did not reset odd bits");

	a_reserved_zero: assert property ( // R21
		(WB_ACK_O && $past(hit(WB_ADR_I, `USC_OFF_CTRL) && rd_en))
		|-> WB_DAT_O[7:6] == 2'h0 && WB_DAT_O[4:3] == 2'h0
		&& WB_DAT_O[1] == 1'b0)
		else $error("reserved control bits not zero");

	a_err_en_write: assert property ( // R1
		(wr_en && hit(WB_ADR_I, `USC_OFF_ERR_EN)) |=>
		st_r.err_en == ($past(wbyte) & `USC_ERR_USED))
		else $error("error enable write lost");

	a_err_all_masked: assert property ( // R2
		(st_r.err_en == `USC_RST_BYTE) |-> !ERR_IRQ)
		else $error("error irq with all sources masked");

	a_err_crc5_irq: assert property ( // R3
		(st_r.err_flag[`USC_ERR_CRC5] && st_r.err_en[`USC_ERR_CRC5])
		|-> ERR_IRQ)
		else $error("crc5 error not raising irq");

	a_err_flag_clear: assert property ( // R20
		(wr_en && hit(WB_ADR_I, `USC_OFF_ERR_FLAG)
		&& wbyte[`USC_ERR_PID] && !ERR_EVT[`USC_ERR_PID])
		|=> !st_r.err_flag[`USC_ERR_PID])
		else $error("error flag not cleared by write one");

	a_err_unused_zero: assert property ( // R21
		(st_r.err_en & ~`USC_ERR_USED) == `USC_RST_BYTE
		&& (st_r.err_flag & ~`USC_ERR_USED) == `USC_RST_BYTE)
		else $error("unused error bit set");

	a_report_stable: assert property ( // R4
		st_r.tok_flag |=> $stable(st_r.report))
		else $error("report changed while token flag set");

	a_queue_full_drop: assert property ( // R6
		(TXN_DONE && st_r.cnt == `USC_Q_DEPTH && !pop)
		|=> st_r.cnt == `USC_Q_DEPTH)
		else $error("full status queue miscounted");

	a_tok_clear: assert property ( // R7
		(st_r.tok_flag && wr_en && hit(WB_ADR_I, `USC_OFF_IRQ_FLAG)
		&& wbyte[`USC_IRQ_TOKDONE]) |=> !st_r.tok_flag)
		else $error("token flag not cleared");

	a_tok_empty_low: assert property ( // R7
		(!st_r.tok_flag && st_r.cnt == 3'h0) |=> !st_r.tok_flag)
		else $error("token flag raised with empty queue");

	a_report_dir: assert property ( // R9
		$rose(st_r.tok_flag)
		|-> st_r.report[3] == $past(st_r.q[st_r.rd].in_dir))
		else $error("report direction bit wrong");

	a_report_odd: assert property ( // R10
		$rose(st_r.tok_flag)
		|-> st_r.report[2] == $past(st_r.q[st_r.rd].odd))
		else $error("report bank bit wrong");

	a_hold_clear: assert property ( // R12
		(wr_en && hit(WB_ADR_I, `USC_OFF_CTRL)
		&& !wbyte[`USC_CTL_HOLD] && !SETUP_RX) |=> !XFER_HOLD)
		else $error("hold not cleared by write");

	a_resume_keep: assert property ( // R13
		!(wr_en && hit(WB_ADR_I, `USC_OFF_CTRL))
		|=> $stable(RESUME_DRIVE))
		else $error("resume drive changed without write");

	a_pp_clear_56: assert property ( // R15
		(wr_en && hit(WB_ADR_I, `USC_OFF_CTRL)
		&& wbyte[`USC_CTL_PPCLR]
		&& (st_r.enable || !wbyte[`USC_CTL_ENABLE]))
		|=> ODD_CLR == `USC_EP_PINGPONG)
		else $error("ping-pong clear not applied");

	a_pp_clear_idle: assert property ( // R15
		!(wr_en && hit(WB_ADR_I, `USC_OFF_CTRL)) |=> ODD_CLR == 7'h00)
		else $error("odd bits cleared without write");

	a_enable_write: assert property ( // R17
		(wr_en && hit(WB_ADR_I, `USC_OFF_CTRL)) |=>
		MOD_EN == $past(wbyte[`USC_CTL_ENABLE]))
		else $error("module enable not following control");

endmodule

/* File: verif/usc_eng_model.sv */
`timescale 1ns/1ps
// Engine side: one finished descriptor per go cycle while hold is low
module usc_eng_model
(
	// Clock
	input  wire logic       clk,
	// Requests from the bench, hold from the block
	input  wire logic       go,
	input  wire logic [5:0] txn,
	input  wire logic       hold,
	// Toward the block
	output logic            txn_done,
	output logic [5:0]      txn_out
);
	initial txn_done = 1'b0;
	initial txn_out = 6'h00;
	always @(posedge clk)
	begin
		txn_done <= go && !hold;
		// Fields are inverted every cycle outside the strobe
		txn_out <= go ? txn : ~txn_out;
	end
endmodule

/* File: verif/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [7:0]  err = 8'h00;
	logic        setup = 1'b0;
	logic        go = 1'b0;
	logic [5:0]  txn = 6'h00;
	logic        ack, done, mod_en, eng_rst, hold, resume, tok, irq;
	logic [31:0] rdat;
	logic [5:0]  tf;
	logic [6:0]  odd_clr;
	logic [6:0]  clr_seen = 7'h00;
	logic [32:0] note;
	logic [32:0] notes[$];
	logic [5:0]  sent[$];
	integer      seed = 32'h9ba242c6;
	int          clr_n = 0;
	int          eng_n = 0;
	int          mismatches = 0;
	int          check_count = 0;

	always #12.5 clk = ~clk;

	usc_regs dut_u
	(.CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
	 .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_ACK_O(ack),
	 .WB_DAT_O(rdat), .ERR_EVT(err), .TXN_DONE(done), .TXN_EP(tf[5:2]),
	 .TXN_IN(tf[1]), .TXN_ODD(tf[0]), .SETUP_RX(setup), .MOD_EN(mod_en),
	 .ENGINE_RST(eng_rst), .ODD_CLR(odd_clr), .XFER_HOLD(hold),
	 .RESUME_DRIVE(resume), .TOK_DONE(tok), .ERR_IRQ(irq));

	usc_eng_model eng_u
	(.clk(clk), .go(go), .txn(txn), .hold(hold), .txn_done(done),
	 .txn_out(tf));

	task give_verdict;
	begin
		if (mismatches == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask

	task automatic chk(input logic ok, input string m);
	begin
		check_count++;
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("mismatch at %0t: %s", $time, m);
		end
	end
	endtask

	// Classic single cycle; read results are noted for the watcher
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] e);
		int n;
		begin
			n = 0;
			notes.push_back({w, e});
			@(posedge clk);
			cyc <= 1'b1;
			stb <= 1'b1;
			we <= w;
			adr <= a;
			wdat <= d;
			sel <= 4'($random(seed)) | 4'h1;
			do
			begin
				@(posedge clk);
				n++;
			end
			while (ack !== 1'b1 && n < 50);
			chk(n < 50, "no ack");
			cyc <= 1'b0;
			stb <= 1'b0;
		end
	endtask

	always @(posedge clk)
	begin
		if (|odd_clr)
			clr_seen <= odd_clr;
		if (|odd_clr)
			clr_n <= clr_n + 1;
		if (eng_rst === 1'b1)
			eng_n <= eng_n + 1;
		if (ack === 1'b1 && notes.size() > 0)
		begin
			note = notes.pop_front();
			if (!note[32])
				chk(rdat === note[31:0], "read data");
		end
	end

	initial
	begin
		#400000;
		mismatches++;
		give_verdict;
	end

	initial
	begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		wb(0, 8'h00, 0, 0);
		wb(0, 8'h08, 0, 0);
		wb(1, 8'h00, 32'hFFFF_FFFF, 0);
		wb(0, 8'h00, 0, 32'h0000_00BF);
		for (int b = 0; b < 8; b++)
		begin
			wb(1, 8'h00, 0, 0);
			@(posedge clk) err <= 8'h01 << b;
			@(posedge clk) err <= 8'h00;
			@(posedge clk);
			chk(irq === 1'b0, "masked error raised");
			wb(1, 8'h00, 32'h1 << b, 0);
			chk(irq === (b != 6), "enabled error");
			wb(0, 8'h0C, 0, (32'h1 << b) & 32'hBF);
			wb(1, 8'h0C, 32'hFF, 0);
			chk(irq === 1'b0, "error flag kept");
		end
		for (int i = 0; i < 6; i++)
		begin
			@(posedge clk);
			go <= 1'b1;
			sent.push_back({4'($unsigned($random(seed)) % 7), 2'($random(seed))});
			txn <= sent[i];
		end
		@(posedge clk) go <= 1'b0;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 5; i++)
		begin
			chk(tok === 1'b1, "token flag low");
			wb(0, 8'h04, 0, {24'h0, sent[i], 2'b00});
			wb(1, 8'h10, 32'h1, 0);
			repeat (2) @(posedge clk);
		end
		chk(tok === 1'b0, "overflow entry kept");
		wb(1, 8'h08, 32'h07, 0);
		wb(0, 8'h08, 0, 32'h05);
		chk(mod_en === 1'b1 && resume === 1'b1, "enable or resume");
		chk(clr_seen === 7'h7F && eng_n == 1, "enable reset");
		wb(1, 8'h08, 32'h03, 0);
		@(posedge clk);
		chk(clr_seen === 7'h60 && clr_n == 2, "ping-pong clear");
		wb(1, 8'h08, 32'h01, 0);
		@(posedge clk);
		chk(resume === 1'b0 && clr_n == 2, "stray clear");
		@(posedge clk) setup <= 1'b1;
		@(posedge clk) setup <= 1'b0;
		wb(1, 8'h08, 32'h21, 0);
		chk(hold === 1'b1, "setup hold");
		@(posedge clk) go <= 1'b1;
		@(posedge clk) go <= 1'b0;
		repeat (3) @(posedge clk);
		chk(tok === 1'b0, "transfer during hold");
		wb(0, 8'h08, 0, 32'h21);
		wb(1, 8'h08, 32'h01, 0);
		chk(hold === 1'b0, "hold not cleared");
		@(posedge clk) go <= 1'b1;
		@(posedge clk) go <= 1'b0;
		repeat (3) @(posedge clk);
		chk(tok === 1'b1, "transfer after hold");
		give_verdict;
	end
endmodule
